/* File: omtc_pkg.sv */
// Purpose: Shared constants for the operating mode and trim control block
// Assumes: Register addresses are 7-bit configuration addresses
// Notes: The source codes name what an output pin carries in each mode
package omtc_pkg;
	// Register addresses
	localparam logic [6:0] ADDR_TRIM = 7'h41;
	localparam logic [6:0] ADDR_MODE = 7'h42;
	localparam logic [6:0] ADDR_BYP = 7'h4d;
	// Field positions
	localparam int BIAS_MSB = 7;
	localparam int BIAS_LSB = 4;
	localparam int TEMP_MSB = 3;
	localparam int TEMP_LSB = 0;
	localparam int MODE_MSB = 3;
	localparam int MODE_LSB = 0;
	localparam int DRV_EN_BIT = 7;
	localparam int BYP_BIT = 5;
	// Reset values: bias trim nominal, threshold trim lowest, mode normal
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] BYP_RST = 8'h00;
	// Operating mode codes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CAL1 = 4'h1;
	localparam logic [3:0] MODE_CAL2 = 4'h2;
	localparam logic [3:0] MODE_TEST1 = 4'h3;
	localparam logic [3:0] MODE_TEST2 = 4'h4;
	localparam logic [3:0] MODE_TEST3 = 4'h5;
	localparam logic [3:0] MODE_TEST4 = 4'h6;
	localparam logic [3:0] MODE_CAL3 = 4'h7;
	localparam logic [3:0] MODE_SAT_LOW = 4'h8;
	localparam logic [3:0] MODE_TEST5 = 4'ha;
	localparam logic [3:0] MODE_IDDQ = 4'he;
	// Alarm setup used for temperature calibration
	localparam logic [7:0] ALARM_MASK_TEMP = 8'h20;
	localparam logic [7:0] ALARM_DELAY_NONE = 8'h00;
	// Pin source codes
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_NORMAL = 3'h1;
	localparam logic [2:0] SRC_CAL1 = 3'h2;
	localparam logic [2:0] SRC_CAL2 = 3'h3;
	localparam logic [2:0] SRC_CAL3 = 3'h4;
	localparam logic [2:0] SRC_TESTPT = 3'h5;
	localparam logic [2:0] SRC_BYPASS = 3'h6;
	localparam logic [2:0] SRC_VENDOR = 3'h7;
	localparam int NUM_PINS = 6;
endpackage

/* File: omtc_ctrl.sv */
// Purpose: Operating mode selection, pin routing and trim register control
// Assumes: Config writes arrive as single-cycle strobes on clk
// Notes: Analog comparator and error inputs are asynchronous and synchronised
//
// Operation
// - Line drivers and polarity protection on only in normal mode zero.
// - Mode one routes bias, references, channel zero; alarm stays normal.
// - Mode two puts channel one and two signals on four pins.
// - Mode seven shows sensor and threshold voltages; alarm stays normal.
// - Mode eight drives serial clock, serial data and alarm low.
// - Mode six: bypass clear gives test points, set feeds inputs through.
// - Bias trim sits in bits 7:4 of 0x41, code 0x8 nominal.
// - Threshold trim sits in bits 3:0 of 0x41, code 0x0 lowest.
// - With mask 0x20, delay 0x00, alarm fires when sensor meets threshold in modes 0, 1, 5 and 7.
// - New mode applies only when written with drive enable bit set.
`timescale 1ns/1ps
module omtc_ctrl
	import omtc_pkg::*;
(
	// Clock, reset, freeze
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Configuration register port
	input wire logic cfg_wr,
	input wire logic [6:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// Alarm setup from other configuration registers
	input wire logic [7:0] alarm_event_mask,
	input wire logic [7:0] alarm_delay_setting,
	// Asynchronous analog status
	input wire logic internal_error_signal,
	input wire logic temp_reached,
	// Output stage control
	output logic output_drive_enable,
	output logic [omtc_pkg::NUM_PINS-1:0][2:0] pin_src,
	output logic test_route_en,
	output logic sat_low,
	output logic alarm_o,
	output logic [3:0] bias_trim,
	output logic [3:0] temp_threshold_trim,
	output logic analog_bypass
);
	import omtc_pkg::*;

	typedef struct packed {
		logic [7:0] trim_r;
		logic [7:0] mode_reg_r;
		logic [7:0] byp_reg_r;
		logic [3:0] act_mode_r;
		logic drv_r;
		logic [NUM_PINS-1:0][2:0] src_r;
		logic test_r;
		logic sat_r;
		logic alarm_r;
		logic [7:0] rdata_r;
		logic err_meta_r;
		logic err_sync_r;
		logic tmp_meta_r;
		logic tmp_sync_r;
	} omtc_state_t;

	omtc_state_t r;
	omtc_state_t n;

	// Source carried by one pin for a given mode and bypass setting
	function automatic logic [2:0] route(input logic [3:0] m, input logic analog_bypass_control,
		input int idx);
		logic [2:0] s;
		s = SRC_OFF;
		case (m)
			MODE_NORMAL: s = SRC_NORMAL;
			MODE_CAL1: s = SRC_CAL1;
			MODE_CAL2: s = (idx < 4) ? SRC_CAL2 : SRC_OFF;
			MODE_TEST1, MODE_TEST2, MODE_TEST3: s = SRC_VENDOR;
			MODE_TEST4: s = analog_bypass_control ? SRC_BYPASS : SRC_TESTPT;
			MODE_CAL3: s = (idx < 2) ? SRC_CAL3 : SRC_OFF;
			MODE_TEST5: s = (idx == 2 || idx == 3) ? SRC_VENDOR : SRC_OFF;
			default: s = SRC_OFF;
		endcase
		return s;
	endfunction

	// Modes that open any calibration or test path
	function automatic logic is_test(input logic [3:0] m);
		logic t;
		t = 1'b0;
		case (m)
			MODE_CAL1, MODE_CAL2, MODE_TEST1, MODE_TEST2, MODE_TEST3,
			MODE_TEST4, MODE_CAL3, MODE_TEST5: t = 1'b1;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	logic wr_trim;
	logic wr_mode;
	logic wr_byp;
	logic temp_hit;
	logic err_norm;

	// Write decode
	assign wr_trim = cfg_wr && (cfg_addr == ADDR_TRIM);
	assign wr_mode = cfg_wr && (cfg_addr == ADDR_MODE);
	assign wr_byp = cfg_wr && (cfg_addr == ADDR_BYP);

	// Temperature warning counts only with the calibration alarm setup
	assign temp_hit = r.tmp_sync_r && (alarm_event_mask == ALARM_MASK_TEMP)
		&& (alarm_delay_setting == ALARM_DELAY_NONE);
	assign err_norm = r.err_sync_r || temp_hit;

	// Next state
	always_comb begin
		n = r;
		// Synchronisers: first stage feeds only the second
		n.err_meta_r = internal_error_signal;
		n.err_sync_r = r.err_meta_r;
		n.tmp_meta_r = temp_reached;
		n.tmp_sync_r = r.tmp_meta_r;
		if (wr_trim) begin
			n.trim_r = cfg_wdata;
		end
		if (wr_byp) begin
			n.byp_reg_r = cfg_wdata;
		end
		if (wr_mode) begin
			n.mode_reg_r = cfg_wdata;
			// Mode switch waits for the enable bit so drivers never glitch
			if (cfg_wdata[DRV_EN_BIT]) begin
				n.act_mode_r = cfg_wdata[MODE_MSB:MODE_LSB];
			end
		end
		// Drivers need both the enable bit and normal mode
		n.drv_r = n.mode_reg_r[DRV_EN_BIT] && (n.act_mode_r == MODE_NORMAL);
		for (int i = 0; i < NUM_PINS; i++) begin
			n.src_r[i] = route(n.act_mode_r, n.byp_reg_r[BYP_BIT], i);
		end
		n.test_r = is_test(n.act_mode_r);
		n.sat_r = (n.act_mode_r == MODE_SAT_LOW);
		// Alarm pin function per mode
		case (n.act_mode_r)
			MODE_NORMAL, MODE_CAL1, MODE_TEST3, MODE_CAL3: begin
				n.alarm_r = err_norm;
			end
			MODE_TEST1, MODE_TEST2, MODE_TEST4: n.alarm_r = r.err_sync_r;
			default: n.alarm_r = 1'b0;
		endcase
		// Read mux; unmapped addresses read zero
		case (cfg_addr)
			ADDR_TRIM: n.rdata_r = r.trim_r;
			ADDR_MODE: n.rdata_r = r.mode_reg_r;
			ADDR_BYP: n.rdata_r = r.byp_reg_r;
			default: n.rdata_r = 8'h00;
		endcase
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.trim_r <= TRIM_RST;
			r.mode_reg_r <= MODE_RST;
			r.byp_reg_r <= BYP_RST;
			r.act_mode_r <= MODE_NORMAL;
		end else if (ce) begin
			r <= n;
		end
	end

	// Outputs straight from flops
	assign cfg_rdata = r.rdata_r;
	assign output_drive_enable = r.drv_r;
	assign pin_src = r.src_r;
	assign test_route_en = r.test_r;
	assign sat_low = r.sat_r;
	assign alarm_o = r.alarm_r;
	assign bias_trim = r.trim_r[BIAS_MSB:BIAS_LSB];
	assign temp_threshold_trim = r.trim_r[TEMP_MSB:TEMP_LSB];
	assign analog_bypass = r.byp_reg_r[BYP_BIT];

	// Checks
	sequence s_mode_apply;
		ce && wr_mode && cfg_wdata[DRV_EN_BIT];
	endsequence

	sequence s_mode_keep;
		ce && wr_mode && !cfg_wdata[DRV_EN_BIT];
	endsequence

	sequence s_temp_hold;
		(ce && temp_reached && r.act_mode_r == MODE_CAL3 && !wr_mode
		&& alarm_event_mask == ALARM_MASK_TEMP
		&& alarm_delay_setting == ALARM_DELAY_NONE)[*3];
	endsequence

	AST_DRV_NORMAL_ONLY: assert property (@(posedge clk)
		disable iff (!nrst)
		output_drive_enable |-> (r.act_mode_r == MODE_NORMAL)
		&& r.mode_reg_r[DRV_EN_BIT])
		else $error("drivers on outside normal mode");

	AST_CAL1_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
		(r.act_mode_r == MODE_CAL1) && !$changed(r.act_mode_r) |->
		(pin_src[0] == SRC_CAL1) && (pin_src[5] == SRC_CAL1)
		&& !output_drive_enable)
		else $error("calibration one routing wrong");

	AST_CAL2_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
		(r.act_mode_r == MODE_CAL2) && !$changed(r.act_mode_r) |->
		(pin_src[3] == SRC_CAL2) && (pin_src[4] == SRC_OFF))
		else $error("calibration two routing wrong");

	AST_CAL3_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
		(r.act_mode_r == MODE_CAL3) && !$changed(r.act_mode_r) |->
		(pin_src[1] == SRC_CAL3) && (pin_src[2] == SRC_OFF))
		else $error("calibration three routing wrong");

	AST_SAT_LOW: assert property (@(posedge clk) disable iff (!nrst)
		s_mode_apply ##0 (cfg_wdata[MODE_MSB:MODE_LSB] == MODE_SAT_LOW)
		|=> sat_low && !alarm_o && !output_drive_enable)
		else $error("saturation low not driven");

	AST_BYPASS_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
		s_mode_apply ##0 (cfg_wdata[MODE_MSB:MODE_LSB] == MODE_TEST4)
		|=> pin_src[0] == (analog_bypass ? SRC_BYPASS : SRC_TESTPT))
		else $error("test four routing wrong");

	AST_BIAS_TRIM: assert property (@(posedge clk) disable iff (!nrst)
		ce && wr_trim |=> bias_trim == $past(cfg_wdata[BIAS_MSB:BIAS_LSB]))
		else $error("bias trim not stored");

	AST_TEMP_TRIM: assert property (@(posedge clk) disable iff (!nrst)
		ce && wr_trim |=>
		temp_threshold_trim == $past(cfg_wdata[TEMP_MSB:TEMP_LSB]))
		else $error("threshold trim not stored");

	AST_TEMP_ALARM: assert property (@(posedge clk) disable iff (!nrst)
		s_temp_hold |=> alarm_o)
		else $error("temperature warning missed on alarm");

	AST_MODE_APPLY: assert property (@(posedge clk) disable iff (!nrst)
		s_mode_apply |=> r.act_mode_r == $past(cfg_wdata[MODE_MSB:MODE_LSB]))
		else $error("mode not applied");

	AST_MODE_KEEP: assert property (@(posedge clk) disable iff (!nrst)
		s_mode_keep |=> $stable(r.act_mode_r) && !output_drive_enable)
		else $error("mode changed without enable bit");

	AST_RESERVED: assert property (@(posedge clk) disable iff (!nrst)
		s_mode_apply ##0 (cfg_wdata[MODE_MSB:MODE_LSB] == 4'hb) |=>
		!test_route_en && (pin_src == '0) && !alarm_o)
		else $error("reserved mode drives pins");
endmodule

/* File: test_operating_mode_and_trim_control.sv */
// Purpose: Self-checking bench for the operating mode and trim control block
// Assumes: Outputs settle one clk edge after a write strobe is taken
// Notes: Mode codes are changed in two writes, code first, then enable bit
`timescale 1ns/1ps
module test_operating_mode_and_trim_control;
	import omtc_pkg::*;
	logic clk, nrst, ce, cfg_wr, internal_error_signal, temp_reached;
	logic [6:0] cfg_addr;
	logic [7:0] cfg_wdata, cfg_rdata, alarm_event_mask, alarm_delay_setting;
	logic output_drive_enable, test_route_en, sat_low, alarm_o, analog_bypass;
	logic [NUM_PINS-1:0][2:0] pin_src;
	logic [3:0] bias_trim, temp_threshold_trim;
	int bad_count, checked;
	logic [18:0] outs;

	omtc_ctrl i_dut (.clk(clk), .nrst(nrst), .ce(ce), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.alarm_event_mask(alarm_event_mask),
		.alarm_delay_setting(alarm_delay_setting),
		.internal_error_signal(internal_error_signal),
		.temp_reached(temp_reached),
		.output_drive_enable(output_drive_enable), .pin_src(pin_src),
		.test_route_en(test_route_en), .sat_low(sat_low), .alarm_o(alarm_o),
		.bias_trim(bias_trim), .temp_threshold_trim(temp_threshold_trim),
		.analog_bypass(analog_bypass));

	// Test route flag above the six pin source codes, as one word
	assign outs = {test_route_en, pin_src};

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Single compare point, so every mismatch is counted the same way
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe; outputs are looked at once the edge has landed
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_wr <= 1'b0;
		#1;
	endtask

	// New mode code goes in with the enable bit clear, then again with it
	// set, so bits 6:0 never change in the applying write
	task set_mode(input logic [3:0] m);
		wr(ADDR_MODE, {4'h0, m});
		wr(ADDR_MODE, {4'h8, m});
	endtask

	// Read data is registered, so it shows one edge after the address
	task rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk);
		cfg_addr <= a;
		@(posedge clk);
		#1;
		chk(cfg_rdata, e);
	endtask

	// Settings are not synchronised, so they land one edge ahead; the async
	// pins then hold the old alarm level for two edges, follow on the third
	task alarm_chk(input logic [7:0] mk, input logic [7:0] dl,
		input logic er, input logic tr, input logic ex);
		logic prev;
		@(posedge clk);
		alarm_event_mask <= mk;
		alarm_delay_setting <= dl;
		@(posedge clk);
		internal_error_signal <= er;
		temp_reached <= tr;
		#1;
		prev = alarm_o;
		repeat (2) @(posedge clk);
		#1;
		chk(alarm_o, prev);
		@(posedge clk);
		#1;
		chk(alarm_o, ex);
	endtask

	// Expected test route flag above the six pin source codes
	function logic [18:0] exp_mode(input logic [3:0] m, input logic b);
		case (m)
			MODE_NORMAL: exp_mode = {1'b0, {6{SRC_NORMAL}}};
			MODE_CAL1: exp_mode = {1'b1, {6{SRC_CAL1}}};
			MODE_CAL2: exp_mode = {1'b1, SRC_OFF, SRC_OFF, {4{SRC_CAL2}}};
			MODE_TEST1, MODE_TEST2, MODE_TEST3: begin
				exp_mode = {1'b1, {6{SRC_VENDOR}}};
			end
			MODE_TEST5: exp_mode = {1'b1, {2{SRC_OFF}}, {2{SRC_VENDOR}},
				{2{SRC_OFF}}};
			MODE_TEST4: exp_mode = {1'b1, {6{b ? SRC_BYPASS : SRC_TESTPT}}};
			MODE_CAL3: exp_mode = {1'b1, {4{SRC_OFF}}, {2{SRC_CAL3}}};
			default: exp_mode = 19'h0;
		endcase
	endfunction

	task finish_test;
		$display("counts: checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog so a stuck run still reaches the verdict
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test;
	end

	// Main sequence
	initial begin
		bad_count = 0;
		checked = 0;
		nrst = 1'b0;
		ce = 1'b1;
		cfg_wr = 1'b0;
		cfg_addr = 7'h00;
		cfg_wdata = 8'h00;
		alarm_event_mask = 8'h00;
		alarm_delay_setting = 8'h00;
		internal_error_signal = 1'b0;
		temp_reached = 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_TRIM, TRIM_RST);
		rd(ADDR_MODE, MODE_RST);
		rd(ADDR_BYP, BYP_RST);
		rd(7'h40, 8'h00);
		chk(output_drive_enable, 1'b0);
		chk({bias_trim, temp_threshold_trim}, TRIM_RST);
		$display("test reset done");
		wr(ADDR_TRIM, 8'h9f);
		chk({bias_trim, temp_threshold_trim}, 8'h9f);
		wr(ADDR_TRIM, 8'hf0);
		chk({bias_trim, temp_threshold_trim}, 8'hf0);
		// Frozen clock enable must swallow a write
		@(posedge clk);
		ce <= 1'b0;
		wr(ADDR_TRIM, 8'h5a);
		@(posedge clk);
		ce <= 1'b1;
		wr(7'h40, 8'hff);
		rd(ADDR_TRIM, 8'hf0);
		rd(7'h40, 8'h00);
		$display("test trims done");
		for (int i = 0; i < 16; i++) begin
			set_mode(i[3:0]);
			chk(output_drive_enable, i == 0);
			chk(sat_low, i == 8);
			chk(outs, exp_mode(i[3:0], 1'b0));
		end
		wr(ADDR_BYP, 8'h20);
		chk(analog_bypass, 1'b1);
		set_mode(MODE_TEST4);
		chk({test_route_en, pin_src}, exp_mode(MODE_TEST4, 1'b1));
		rd(ADDR_BYP, 8'h20);
		$display("test modes done");
		// Mode change without the enable bit must not take effect
		set_mode(MODE_CAL3);
		wr(ADDR_MODE, 8'h02);
		chk({test_route_en, pin_src}, exp_mode(MODE_CAL3, 1'b0));
		chk(output_drive_enable, 1'b0);
		rd(ADDR_MODE, 8'h02);
		wr(ADDR_MODE, 8'h82);
		chk({test_route_en, pin_src}, exp_mode(MODE_CAL2, 1'b0));
		$display("test enable bit done");
		set_mode(MODE_CAL3);
		alarm_chk(8'h20, 8'h00, 1'b0, 1'b1, 1'b1);
		alarm_chk(8'h21, 8'h00, 1'b0, 1'b1, 1'b0);
		alarm_chk(8'h20, 8'h01, 1'b0, 1'b1, 1'b0);
		set_mode(MODE_CAL1);
		alarm_chk(8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
		set_mode(MODE_SAT_LOW);
		alarm_chk(8'h20, 8'h00, 1'b1, 1'b1, 1'b0);
		set_mode(MODE_NORMAL);
		alarm_chk(8'h20, 8'h00, 1'b0, 1'b1, 1'b1);
		alarm_chk(8'h20, 8'h00, 1'b0, 1'b0, 1'b0);
		$display("test alarm done");
		// Reset in mid-run must bring back the trim and mode register values
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_TRIM, TRIM_RST);
		rd(ADDR_MODE, MODE_RST);
		chk(output_drive_enable, 1'b0);
		chk(outs, exp_mode(MODE_NORMAL, 1'b0));
		$display("test second reset done");
		finish_test;
	end
endmodule
